// file: rtl/iocc_pkg.sv
// Purpose: Constants for the I/O channel converter control block
// Assumes: 8 I/O channels, 12-bit codes, 16-bit register words
// Notes:   Pointer nibbles, register selects and field positions
// Contract
// R1: Pointer upper nibble zero selects control registers
// R2: Reset: all channels pull-down, no function
// R3: Bit n of function register assigns channel n
// R4: Conflicting functions: most recent write wins
// R5: DAC plus ADC allowed, DAC drives
// R6: GPIO in plus out drives, reads output
// R7: Lock bit set discards pin-function writes
// R8: Controller reconfigures only idle and unlocked
// R9: Pointer nibble 0001 writes DAC, bits 2:0 select
// R10: DAC data bytes stored into input register
// R11: Two-bit load-transfer mode field, 11 reserved
// R12: Mode 00 copies input to DAC at once
// R13: Mode 01 holds DAC registers unchanged
// R14: Mode 10 copies all, then reverts 01
// R15: Readback nibble 0101 selects DAC input register
// R16: Readback word: flag, address, 12-bit code
// R17: Sequence write starts tracking first channel
// R18: Channels converted ascending, one per result
// R19: Conversion starts at ACK before result MSB
// R20: End: repeat restarts, else final result repeats
// R21: New sequence abandons old, starts first channel
// R22: Clearing sequence register stops sequencing
// R23: Write-all loads every DAC-configured channel
// R24: Sequence: repeat bit 9, temperature 8, channels
// R25: Lock is bit 7 of control register
package iocc_pkg;
  localparam int NCH = 8;
  localparam int CODE_W = 12;
  localparam logic [3:0] PTR_CTRL = 4'h0;
  localparam logic [3:0] PTR_DAC_WR = 4'h1;
  localparam logic [3:0] PTR_ADC_RD = 4'h4;
  localparam logic [3:0] PTR_DAC_RD = 4'h5;
  localparam logic [3:0] PTR_GPIO_RD = 4'h6;
  localparam logic [3:0] REG_SEQ = 4'h2;
  localparam logic [3:0] REG_GPCTL = 4'h3;
  localparam logic [3:0] REG_ADC_CFG = 4'h4;
  localparam logic [3:0] REG_DAC_CFG = 4'h5;
  localparam logic [3:0] REG_PULLDOWN = 4'h6;
  localparam logic [3:0] REG_LOAD_MODE = 4'h7;
  localparam logic [3:0] REG_GPO_CFG = 4'h8;
  localparam logic [3:0] REG_GPO_DATA = 4'h9;
  localparam logic [3:0] REG_GPI_CFG = 4'ha;
  localparam int GPCTL_LOCK_BIT = 7;
  localparam int GPCTL_WRALL_BIT = 6;
  localparam int SEQ_REP_BIT = 9;
  localparam int SEQ_TEMP_BIT = 8;
  localparam int READBACK_FLAG_BIT = 15;
  localparam logic [1:0] LOAD_IMMEDIATE = 2'b00;
  localparam logic [1:0] LOAD_HOLD = 2'b01;
  localparam logic [1:0] LOAD_COPY_ALL = 2'b10;
  localparam logic [1:0] LOAD_RESERVED = 2'b11;
  localparam logic [7:0] PULLDOWN_RST = 8'hff;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [9:0] SEQ_RST = 10'h000;
  localparam logic [15:0] GPCTL_RST = 16'h0000;
  localparam logic [3:0] TEMP_CHANNEL = 4'h8;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = 24;
endpackage

// file: rtl/iocc_core.sv
// Purpose: I2C target command logic, pin functions, DAC and ADC control
// Assumes: scl and sda come from pins; converter answers adc_done
// Notes:   adc_done must follow adc_start within 2 mclk cycles
`timescale 1ns/1ps
module iocc_core
  import iocc_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2a, // Arbitrary value
  parameter int         DEPTH       = BUF_DEPTH
) (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire logic               scl_pin,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  input  wire logic [NCH-1:0]     gpio_in,
  output logic      [NCH-1:0]     gpio_out,
  output logic      [NCH-1:0]     gpio_oe,
  output logic      [NCH-1:0]     io_dac_en,
  output logic      [NCH-1:0]     io_adc_en,
  output logic      [NCH-1:0]     io_pulldown_en,
  output logic      [15:0]        gp_control,
  output logic      [NCH*CODE_W-1:0] dac_code,
  output logic                    adc_start,
  output logic      [3:0]         adc_channel,
  input  wire logic [CODE_W-1:0]  adc_result,
  input  wire logic               adc_done,
  output logic                    adc_active
);

  if (DEPTH != 2 && DEPTH != 4) begin : g_bad_depth
    $error("DEPTH must be 2 or 4");
  end

  localparam int AW = $clog2(DEPTH);

  typedef enum logic [2:0] {
    st_idle, st_start, st_addr, st_addr_ack, st_wr, st_wr_ack, st_rd,
    st_rd_ack
  } iocc_state_t;

  // Pin synchronisers
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic [NCH-1:0] gpi_s1, gpi_s2;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      {scl_s1, scl_s2, scl_s3} <= 3'b111;
      {sda_s1, sda_s2, sda_s3} <= 3'b111;
      gpi_s1 <= 8'h00;
      gpi_s2 <= 8'h00;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_pin, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
      gpi_s1 <= gpio_in;
      gpi_s2 <= gpi_s1;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise  = scl_s2 & ~scl_s3;
  assign scl_fall  = ~scl_s2 & scl_s3;
  assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // Registers
  logic [7:0]  adc_cfg, dac_cfg, gpo_cfg, gpi_cfg, pd_cfg, gpo_data;
  logic [15:0] gpctl;
  logic [9:0]  seq;
  logic [1:0]  load_mode;
  logic [CODE_W-1:0] in_reg [NCH];
  logic [15:0] adc_word;
  logic [3:0]  cur_ch;
  logic        seq_done;
  logic [7:0]  gpio_rd;

  // Command buffer of DEPTH entries (2 or 4)
  logic [BUF_W-1:0] buf_mem [DEPTH];
  logic [AW:0]      buf_wp, buf_rp;
  logic             buf_full, buf_empty, push_valid, push_ready;
  logic             pop_valid, pop_ready, pop;
  logic [BUF_W-1:0] push_data, pop_data;
  assign buf_full   = (buf_wp[AW] != buf_rp[AW]) &&
                      (buf_wp[AW-1:0] == buf_rp[AW-1:0]);
  assign buf_empty  = buf_wp == buf_rp;
  assign push_ready = ~buf_full;
  assign pop_valid  = ~buf_empty;
  assign pop_data   = buf_mem[buf_rp[AW-1:0]];
  assign pop        = pop_valid & pop_ready;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      buf_wp <= '0;
      buf_rp <= '0;
    end else begin
      if (push_valid && push_ready) begin
        buf_mem[buf_wp[AW-1:0]] <= push_data;
        buf_wp <= buf_wp + 1'b1;
      end
      if (pop) begin
        buf_rp <= buf_rp + 1'b1;
      end
    end
  end

  // Decoded command from buffer head
  logic [7:0]  cmd_ptr;
  logic [15:0] cmd_data;
  logic        cmd_ctrl, cmd_dac, fn_write;
  assign cmd_ptr  = pop_data[23:16];
  assign cmd_data = pop_data[15:0];
  assign cmd_ctrl = pop && cmd_ptr[7:4] == PTR_CTRL; // R1
  assign cmd_dac  = pop && cmd_ptr[7:4] == PTR_DAC_WR; // R9
  assign fn_write = cmd_ctrl && !gpctl[GPCTL_LOCK_BIT]; // R7 R25

  // Pin functions; newest write clears clashing functions
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adc_cfg <= CFG_RST; // R2
      dac_cfg <= CFG_RST;
      gpo_cfg <= CFG_RST;
      gpi_cfg <= CFG_RST;
      pd_cfg  <= PULLDOWN_RST;
    end else if (fn_write) begin
      unique case (cmd_ptr[3:0])
        REG_ADC_CFG: begin
          adc_cfg <= cmd_data[7:0]; // R3
          gpo_cfg <= gpo_cfg & ~cmd_data[7:0]; // R4 R5
          gpi_cfg <= gpi_cfg & ~cmd_data[7:0];
          pd_cfg  <= pd_cfg & ~cmd_data[7:0];
        end
        REG_DAC_CFG: begin
          dac_cfg <= cmd_data[7:0]; // R3
          gpo_cfg <= gpo_cfg & ~cmd_data[7:0]; // R4 R5
          gpi_cfg <= gpi_cfg & ~cmd_data[7:0];
          pd_cfg  <= pd_cfg & ~cmd_data[7:0];
        end
        REG_GPO_CFG: begin
          gpo_cfg <= cmd_data[7:0]; // R3
          adc_cfg <= adc_cfg & ~cmd_data[7:0]; // R4 R6
          dac_cfg <= dac_cfg & ~cmd_data[7:0];
          pd_cfg  <= pd_cfg & ~cmd_data[7:0];
        end
        REG_GPI_CFG: begin
          gpi_cfg <= cmd_data[7:0]; // R3
          adc_cfg <= adc_cfg & ~cmd_data[7:0]; // R4 R6
          dac_cfg <= dac_cfg & ~cmd_data[7:0];
          pd_cfg  <= pd_cfg & ~cmd_data[7:0];
        end
        REG_PULLDOWN: begin
          pd_cfg  <= cmd_data[7:0]; // R3
          adc_cfg <= adc_cfg & ~cmd_data[7:0]; // R4
          dac_cfg <= dac_cfg & ~cmd_data[7:0];
          gpo_cfg <= gpo_cfg & ~cmd_data[7:0];
          gpi_cfg <= gpi_cfg & ~cmd_data[7:0];
        end
        default: ;
      endcase
    end
  end

  // Control, GPIO data and load-transfer mode
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gpctl     <= GPCTL_RST;
      gpo_data  <= CFG_RST;
      load_mode <= LOAD_IMMEDIATE; // R12
    end else if (cmd_ctrl) begin
      if (cmd_ptr[3:0] == REG_GPCTL) begin
        gpctl <= cmd_data;
      end
      if (cmd_ptr[3:0] == REG_GPO_DATA) begin
        gpo_data <= cmd_data[7:0];
      end
      if (cmd_ptr[3:0] == REG_LOAD_MODE) begin
        if (cmd_data[1:0] == LOAD_COPY_ALL) begin
          load_mode <= LOAD_HOLD; // R14
        end else if (cmd_data[1:0] != LOAD_RESERVED) begin
          load_mode <= cmd_data[1:0]; // R11
        end
      end
    end
  end

  logic copy_all;
  assign copy_all = cmd_ctrl && cmd_ptr[3:0] == REG_LOAD_MODE &&
                    cmd_data[1:0] == LOAD_COPY_ALL;

  // Per-channel DAC input and DAC registers
  for (genvar i = 0; i < NCH; i++) begin : g_dac
    logic hit;
    assign hit = cmd_dac && (gpctl[GPCTL_WRALL_BIT] ? dac_cfg[i] // R23
                 : cmd_ptr[2:0] == 3'(i)); // R9
    always_ff @(posedge mclk) begin
      if (!reset_n) begin
        in_reg[i] <= '0;
        dac_code[i*CODE_W +: CODE_W] <= '0;
      end else begin
        if (hit) begin
          in_reg[i] <= cmd_data[CODE_W-1:0]; // R10
        end
        if (hit && load_mode == LOAD_IMMEDIATE) begin
          dac_code[i*CODE_W +: CODE_W] <= cmd_data[CODE_W-1:0]; // R12
        end else if (copy_all) begin
          dac_code[i*CODE_W +: CODE_W] <= in_reg[i]; // R14 R13
        end
      end
    end
  end

  // Sequence search helpers
  logic [8:0] seq_mask;
  assign seq_mask = {seq[SEQ_TEMP_BIT], seq[7:0]};

  function automatic logic [3:0] first_ch(input logic [8:0] m);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 8; k >= 0; k--) begin
      if (m[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] next_ch(input logic [8:0] m,
                                          input logic [3:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 8; k >= 0; k--) begin
      if (m[k] && 4'(k) > c) begin
        r = {1'b1, 4'(k)};
      end
    end
    return r;
  endfunction

  // ADC sequencer
  logic       conv_trig;
  logic [4:0] nxt;
  logic       seq_write;
  assign nxt       = next_ch(seq_mask, cur_ch);
  assign seq_write = cmd_ctrl && cmd_ptr[3:0] == REG_SEQ;
  assign adc_active = |seq_mask && !seq_done; // R22
  assign pop_ready = ~conv_trig;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      seq       <= SEQ_RST; // R24
      cur_ch    <= 4'h0;
      seq_done  <= 1'b0;
      adc_start <= 1'b0;
      adc_channel <= 4'h0;
    end else begin
      adc_start <= 1'b0;
      if (seq_write) begin
        seq      <= cmd_data[9:0]; // R24
        cur_ch   <= first_ch({cmd_data[SEQ_TEMP_BIT], cmd_data[7:0]});
        seq_done <= 1'b0; // R17 R21
      end else if (conv_trig && adc_active) begin
        adc_start   <= 1'b1; // R19
        adc_channel <= cur_ch;
        if (nxt[4]) begin
          cur_ch <= nxt[3:0]; // R18
        end else if (seq[SEQ_REP_BIT]) begin
          cur_ch <= first_ch(seq_mask); // R20
        end else begin
          seq_done <= 1'b1; // R20
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adc_word <= 16'h0000;
    end else if (adc_done) begin
      adc_word <= {adc_channel, adc_result};
    end
  end

  // Pin function outputs
  assign io_dac_en      = dac_cfg; // R5
  assign io_adc_en      = adc_cfg;
  assign io_pulldown_en = pd_cfg;
  assign gp_control     = gpctl;
  assign gpio_oe        = gpo_cfg; // R6
  assign gpio_out       = gpo_data & gpo_cfg;
  assign gpio_rd = (gpo_cfg & gpi_cfg & gpo_data) |
                   (gpi_cfg & ~gpo_cfg & gpi_s2); // R6

  // I2C target engine
  iocc_state_t state;
  logic [2:0]  bitcnt;
  logic [7:0]  shreg, txsh, ptr, rd_ptr, msb_byte;
  logic [1:0]  wr_idx;
  logic        rd_lsb, rd_mode;
  logic [15:0] tx_word, next_tx_word;

  always_comb begin
    unique case (rd_ptr[7:4])
      PTR_ADC_RD:  next_tx_word = adc_word; // R20
      PTR_DAC_RD:  next_tx_word = {1'b1, rd_ptr[2:0],
                                   in_reg[rd_ptr[2:0]]}; // R15 R16
      PTR_GPIO_RD: next_tx_word = {8'h00, gpio_rd};
      default:     next_tx_word = 16'h0000;
    endcase
  end

  assign conv_trig = scl_rise && rd_ptr[7:4] == PTR_ADC_RD &&
                     ((state == st_addr_ack && rd_mode) ||
                      (state == st_rd_ack && rd_lsb && !sda_s2)); // R19
  assign sda_out = 1'b0;
  assign push_data = {ptr, msb_byte, shreg};
  assign push_valid = scl_fall && state == st_wr && bitcnt == 3'd0 &&
                      wr_idx == 2'd2 &&
                      (ptr[7:4] == PTR_CTRL || ptr[7:4] == PTR_DAC_WR);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state    <= st_idle;
      bitcnt   <= 3'd0;
      shreg    <= 8'h00;
      txsh     <= 8'h00;
      ptr      <= 8'h00;
      rd_ptr   <= 8'h00;
      msb_byte <= 8'h00;
      wr_idx   <= 2'd0;
      rd_lsb   <= 1'b0;
      rd_mode  <= 1'b0;
      tx_word  <= 16'h0000;
      sda_oe   <= 1'b0;
    end else if (bus_stop) begin
      state  <= st_idle;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      state  <= st_start; // Wait for the START's own SCL fall
      bitcnt <= 3'd0;
      wr_idx <= 2'd0;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (state == st_addr || state == st_wr) begin
        shreg  <= {shreg[6:0], sda_s2};
        bitcnt <= bitcnt + 3'd1;
      end else if (state == st_rd) begin
        bitcnt <= bitcnt + 3'd1;
      end else if (state == st_rd_ack && sda_s2) begin
        state <= st_idle;
      end
    end else if (scl_fall) begin
      unique case (state)
        st_start: state <= st_addr;
        st_addr: if (bitcnt == 3'd0) begin
          if (shreg[7:1] == TARGET_ADDR) begin
            state   <= st_addr_ack;
            rd_mode <= shreg[0];
            sda_oe  <= 1'b1;
          end else begin
            state <= st_idle;
          end
        end
        st_wr: if (bitcnt == 3'd0) begin
          state  <= st_wr_ack;
          sda_oe <= 1'b1;
          if (wr_idx == 2'd0) begin
            ptr    <= shreg;
            wr_idx <= 2'd1;
            if (shreg[7:6] == 2'b01) begin
              rd_ptr <= shreg;
            end
          end else if (wr_idx == 2'd1) begin
            msb_byte <= shreg;
            wr_idx   <= 2'd2;
          end else begin
            sda_oe <= push_ready;
            wr_idx <= 2'd1;
          end
        end
        st_addr_ack, st_rd_ack: begin
          sda_oe <= 1'b0;
          if (state == st_addr_ack && !rd_mode) begin
            state  <= st_wr;
            bitcnt <= 3'd0;
          end else if (rd_lsb || state == st_addr_ack) begin
            tx_word <= next_tx_word;
            txsh    <= {next_tx_word[14:8], 1'b0};
            sda_oe  <= ~next_tx_word[15];
            rd_lsb  <= 1'b0;
            state   <= st_rd;
            bitcnt  <= 3'd0;
          end else begin
            txsh   <= {tx_word[6:0], 1'b0};
            sda_oe <= ~tx_word[7];
            rd_lsb <= 1'b1;
            state  <= st_rd;
            bitcnt <= 3'd0;
          end
        end
        st_wr_ack: begin
          sda_oe <= 1'b0;
          state  <= st_wr;
        end
        st_rd: begin
          if (bitcnt == 3'd0) begin
            state  <= st_rd_ack;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= ~txsh[7];
            txsh   <= {txsh[6:0], 1'b0};
          end
        end
        default: ;
      endcase
    end
  end

  // Checks
  chk_lock_holds_cfg: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd_ctrl && gpctl[GPCTL_LOCK_BIT] |=> $stable(dac_cfg) && $stable(adc_cfg)
    && $stable(pd_cfg)) else $error("Locked config changed"); // R7
  chk_pulldown_reset: assert property (@(posedge mclk)
    $rose(reset_n) |-> io_pulldown_en == PULLDOWN_RST && io_dac_en == 8'h00)
    else $error("Reset pin functions wrong"); // R2
  chk_copy_reverts: assert property (@(posedge mclk) disable iff (!reset_n)
    copy_all |=> load_mode == LOAD_HOLD) else $error("Mode not 01"); // R14
  chk_hold_keeps_dac: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd_dac && load_mode == LOAD_HOLD |=> $stable(dac_code))
    else $error("DAC moved in hold"); // R13
  chk_immediate_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    cmd_dac && load_mode == LOAD_IMMEDIATE && cmd_ptr[2:0] == 3'h0 &&
    !gpctl[GPCTL_WRALL_BIT] |=> dac_code[11:0] == $past(cmd_data[11:0]))
    else $error("DAC not updated"); // R12
  chk_readback_word: assert property (@(posedge mclk) disable iff (!reset_n)
    scl_fall && state == st_addr_ack && rd_mode && rd_ptr[7:4] == PTR_DAC_RD
    |=> tx_word[15] && tx_word[14:12] == rd_ptr[2:0])
    else $error("Readback word format"); // R16
  chk_start_on_ack: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(adc_start) |-> $past(scl_rise) && $past(rd_ptr[7:4]) == PTR_ADC_RD)
    else $error("Conversion start misplaced"); // R19
  chk_seq_restart: assert property (@(posedge mclk) disable iff (!reset_n)
    seq_write |=> cur_ch == first_ch(seq_mask) && !seq_done)
    else $error("Sequence not restarted"); // R21
  chk_fn_exclusive: assert property (@(posedge mclk) disable iff (!reset_n)
    ((dac_cfg | adc_cfg) & (gpo_cfg | gpi_cfg)) == 8'h00 &&
    (pd_cfg & (dac_cfg | adc_cfg | gpo_cfg | gpi_cfg)) == 8'h00)
    else $error("Clashing pin functions"); // R4

endmodule

// file: tb/iocc_i2c_host.sv
// Purpose: I2C controller model facing the target port
// Assumes: SDA pulled up; target pulls low while sda_oe is high
// Notes:   Lines move at falling mclk edges; SCL idles high
`timescale 1ns/1ps
module iocc_i2c_host (
  input  wire logic mclk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic drv;
  int   half;
  assign sda = drv & ~sda_oe;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
    half = 4;
  end
  task automatic pause();
    repeat (half) @(negedge mclk);
  endtask
  // Data moves only while SCL is low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    @(negedge mclk);
    drv = b;
    repeat (half - 1) @(negedge mclk);
    scl = 1'b1;
    pause();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    drv = 1'b1;
    pause();
    scl = 1'b1;
    pause();
    drv = 1'b0;
    pause();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge mclk);
    drv = 1'b0;
    pause();
    scl = 1'b1;
    pause();
    drv = 1'b1;
    pause();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// file: tb/iocc_core_test.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: I2C model partner; converter answers one cycle late
// Notes:   All inputs move at falling mclk edges
`timescale 1ns/1ps
module iocc_core_test;
  import iocc_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  logic                    mclk, reset_n, scl, sda, sda_oe;
  logic                    adc_start, adc_done, adc_active;
  logic [NCH-1:0]          gpio_in, gpio_out, gpio_oe;
  logic [NCH-1:0]          io_dac_en, io_adc_en, io_pulldown_en;
  logic [15:0]             gp_control, starts, s0;
  logic [NCH*CODE_W-1:0]   dac_code;
  logic [3:0]              adc_channel;
  logic [CODE_W-1:0]       adc_result;
  logic [15:0]             got [4];
  int                      fails, check_count;

  iocc_core iocc_core_i (
    .mclk(mclk), .reset_n(reset_n), .scl_pin(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .io_dac_en(io_dac_en),
    .io_adc_en(io_adc_en), .io_pulldown_en(io_pulldown_en),
    .gp_control(gp_control), .dac_code(dac_code),
    .adc_start(adc_start), .adc_channel(adc_channel),
    .adc_result(adc_result), .adc_done(adc_done),
    .adc_active(adc_active)
  );
  iocc_i2c_host iocc_i2c_host_i (
    .mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda)
  );

  // Converter: result tagged by channel, done one cycle later
  assign adc_result = 12'h300 | {8'h00, adc_channel};
  always @(negedge mclk) begin
    adc_done <= adc_start === 1'b1;
    if (!reset_n) begin
      starts <= 16'h0000;
    end else if (adc_start === 1'b1) begin
      starts <= starts + 16'h0001;
    end
  end

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] g, e, input string what);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w);
    logic a0, a1, a2, a3;
    iocc_i2c_host_i.start();
    iocc_i2c_host_i.send({ADDR, 1'b0}, a0);
    iocc_i2c_host_i.send(ptr, a1);
    iocc_i2c_host_i.send(w[15:8], a2);
    iocc_i2c_host_i.send(w[7:0], a3);
    iocc_i2c_host_i.stop();
    check({12'h000, a0, a1, a2, a3}, 16'h000f, "write ack");
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    logic       a0, a1, a2;
    logic [7:0] hi, lo;
    iocc_i2c_host_i.start();
    iocc_i2c_host_i.send({ADDR, 1'b0}, a0);
    iocc_i2c_host_i.send(ptr, a1);
    iocc_i2c_host_i.stop();
    iocc_i2c_host_i.start();
    iocc_i2c_host_i.send({ADDR, 1'b1}, a2);
    for (int i = 0; i < n; i++) begin
      iocc_i2c_host_i.recv(1'b0, hi);
      iocc_i2c_host_i.recv(i == n - 1, lo);
      got[i] = {hi, lo};
    end
    iocc_i2c_host_i.stop();
    check({13'h0000, a0, a1, a2}, 16'h0007, "read ack");
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: about two and a half times the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    logic a;
    reset_n = 1'b0;
    gpio_in = 8'h00;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    check({io_pulldown_en, io_dac_en}, 16'hff00, "pull-down");
    check({io_adc_en, gpio_oe}, 16'h0000, "no function");
    iocc_i2c_host_i.start();
    iocc_i2c_host_i.send({7'h2b, 1'b0}, a);
    iocc_i2c_host_i.stop();
    check({15'h0000, a}, 16'h0000, "foreign address");
    $display("Test reset done");
    wr(8'h05, 16'h0082);
    check({io_dac_en, io_pulldown_en}, 16'h827d, "dac set");
    wr(8'h04, 16'h0081);
    check({io_dac_en, io_adc_en}, 16'h8281, "dac and adc");
    wr(8'h08, 16'h0002);
    check({io_dac_en, gpio_oe}, 16'h8002, "last write");
    wr(8'h0a, 16'h0002);
    wr(8'h09, 16'h0002);
    rd(8'h60, 1);
    check(got[0], 16'h0002, "input reads output");
    check({gpio_oe, gpio_out}, 16'h0202, "output drives");
    wr(8'h03, 16'h0080);
    check(gp_control, 16'h0080, "lock bit");
    wr(8'h05, 16'h00ff);
    wr(8'h06, 16'h00ff);
    check({io_dac_en, io_pulldown_en}, 16'h807c, "locked");
    wr(8'h03, 16'h0000);
    $display("Test pin functions done");
    wr(8'h05, 16'h00ff);
    for (int i = 0; i < 8; i++) begin
      wr(8'(16 + i), 16'h05a0 + 16'(i));
      check({4'h0, dac_code[12*i +: 12]}, 16'h05a0 + 16'(i), "load");
      rd(8'(80 + i), 1);
      check(got[0], {1'b1, 3'(i), 12'h5a0 + 12'(i)}, "readback");
    end
    wr(8'h07, 16'h0001);
    wr(8'h12, 16'h0777);
    wr(8'h07, 16'h0003);
    wr(8'h15, 16'h0555);
    check({4'h0, dac_code[35:24]}, 16'h05a2, "hold mode");
    check({4'h0, dac_code[71:60]}, 16'h05a5, "reserved mode");
    rd(8'h52, 1);
    check(got[0], 16'ha777, "input register");
    wr(8'h07, 16'h0002);
    check({4'h0, dac_code[35:24]}, 16'h0777, "copy all");
    check({4'h0, dac_code[71:60]}, 16'h0555, "copy all");
    wr(8'h16, 16'h0666);
    check({4'h0, dac_code[83:72]}, 16'h05a6, "back to hold");
    wr(8'h07, 16'h0000);
    wr(8'h05, 16'h000f);
    wr(8'h03, 16'h0040);
    wr(8'h17, 16'h0321);
    check({4'h0, dac_code[11:0]}, 16'h0321, "write all");
    check({4'h0, dac_code[47:36]}, 16'h0321, "write all");
    check({4'h0, dac_code[95:84]}, 16'h05a7, "not a dac");
    wr(8'h03, 16'h0000);
    $display("Test dac done");
    wr(8'h04, 16'h00ff);
    s0 = starts;
    wr(8'h02, 16'h0205);
    check({15'h0000, adc_active}, 16'h0001, "active");
    rd(8'h40, 3);
    check(got[0], 16'h0300, "first channel");
    check(got[1], 16'h2302, "ascending");
    check(got[2], 16'h0300, "repeat");
    check(starts - s0, 16'h0003, "one per word");
    wr(8'h02, 16'h0106);
    s0 = starts;
    rd(8'h40, 4);
    check(got[0], 16'h1301, "new first");
    check(got[1], 16'h2302, "ascending");
    check(got[2], 16'h8308, "temperature");
    check(got[3], 16'h8308, "last kept");
    check(starts - s0, 16'h0003, "no restart");
    wr(8'h02, 16'h0000);
    check({15'h0000, adc_active}, 16'h0000, "stopped");
    $display("Test adc done");
    test_done();
  end
endmodule
